// ### design/sacr_regs.sv
`timescale 1ns/1ns
// Operation
// - writing response code sends a response packet with that code
// - csr_autoresp_disable forwards CSR accesses to the general receive FIFO
// - backplane bit selects backplane node-id rules
// - until init_done every request gets ack_tardy
// - serial ROM load completion sets init_done and config_valid
// - config_valid clear routes ROM reads to processor
// - management agent sets mgmt_login_valid itself
// - agent_state reports reset, active, suspended or dead
// - unsol_send transmits status FIFO, clears when FIFO empty
// - rom_quadlet_addr selects target ROM quadlet
// - rom_read_go reads quadlet into buffer, self-clears when done
// - rom_write_go writes buffer to quadlet, self-clears when done
// - 32-bit parameter data buffer holds ROM quadlet
// - non-final status quadlets go through first-and-continue port
// - quadlet port bytes accessed in order from lowest address
// - lowest byte address is most significant byte
// - all bits clear to zero at reset
// - final status quadlet goes through last-quadlet port
// - scsi_status_send transmits status after FIFO loaded; no such bit here, a last-quadlet port write pushes with fifo_last
module sacr_regs (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // host bus
   input wire sacr_pkg::sacr_bus_t bus_i,
   output logic [7:0] rdata_o,
   // pins from outside the clock domain
   input wire logic rom_load_done_i,
   // agent and link events on the same clock
   input wire logic mgmt_login_set_i,
   input wire logic agent_state_wr_i,
   input wire sacr_pkg::sacr_agent_t agent_state_i,
   input wire logic rom_op_done_i,
   input wire logic [31:0] rom_rdata_i,
   input wire logic status_fifo_empty_i,
   // link commands
   output sacr_pkg::sacr_link_t link_o
);


   // width of one byte lane and of the rom quadlet address field
   localparam int BYTE_W = 8;
   localparam int RADDR_W = 6;
   // byte lane of the response code inside the control quadlet
   localparam logic [1:0] RCODE_LANE = 2'(sacr_pkg::LANE_LAST - sacr_pkg::RCODE_LSB / BYTE_W);

   // registered state and the synchroniser pair
   sacr_pkg::sacr_state_t s_q;
   sacr_pkg::sacr_state_t s_d;
   logic [1:0] boot_sync_q;

   // bit offset of a byte lane; lane 0 lands on the most significant byte
   function automatic int lane_pos(input logic [1:0] lane);
      return BYTE_W * (int'(sacr_pkg::LANE_LAST) - int'(lane));
   endfunction : lane_pos

   // replace one byte lane of a quadlet
   function automatic logic [31:0] put_byte(input logic [31:0] q, input logic [1:0] lane,
                                            input logic [7:0] b);
      logic [31:0] r;
      r = q;
      r[lane_pos(lane) +: BYTE_W] = b;
      return r;
   endfunction : put_byte

   // pick one byte lane of a quadlet
   function automatic logic [7:0] get_byte(input logic [31:0] q, input logic [1:0] lane);
      return q[lane_pos(lane) +: BYTE_W];
   endfunction : get_byte

   // quadlet base of a byte address
   function automatic logic [11:0] quad_base(input logic [11:0] addr);
      return {addr[11:2], 2'b00};
   endfunction : quad_base

   // reserved control bits read zero except bits 23:16, which are held; the response code is a one-shot
   // command, so its field is never held and always reads zero
   function automatic logic [31:0] ctrl_clean(input logic [31:0] q);
      logic [31:0] r;
      r = q;
      r[31:24] = 8'h00;
      r[sacr_pkg::RCODE_LSB +: BYTE_W] = 8'h00;
      r[sacr_pkg::RCODE_LSB - 1 -: 4] = 4'h0;
      return r;
   endfunction : ctrl_clean

   // only the login flag, agent state and unsolicited flag are held
   function automatic logic [31:0] stat_clean(input logic [31:0] q);
      logic [31:0] r;
      r = q;
      r[sacr_pkg::UNSOL_BIT - 1:0] = '0;
      return r;
   endfunction : stat_clean

   // only the quadlet address and the two go bits are held
   function automatic logic [31:0] roma_clean(input logic [31:0] q);
      logic [31:0] r;
      r = q;
      r[31:sacr_pkg::RADDR_LSB + RADDR_W] = '0;
      return r;
   endfunction : roma_clean

   // register read mux; unmapped bytes and reserved bytes other than control byte 0x061 read zero
   function automatic logic [7:0] read_byte(input sacr_pkg::sacr_state_t s,
                                            input logic [11:0] qa, input logic [1:0] lane);
      logic [7:0] r;
      r = 8'h00;
      unique case (qa)
         sacr_pkg::CTRL_ADDR: begin
            r = get_byte(s.ctrl, lane);
         end
         sacr_pkg::STAT_ADDR: begin
            r = get_byte(s.stat, lane);
         end
         sacr_pkg::ROMA_ADDR: begin
            r = get_byte(s.roma, lane);
         end
         sacr_pkg::ROMD_ADDR: begin
            r = get_byte(s.romd, lane);
         end
         // the first/continue port reads back the stacked quadlet
         sacr_pkg::FIFO_ADDR: begin
            r = get_byte(s.stack, lane);
         end
         // the last-quadlet port is write only and reads zero
         default: begin
            r = 8'h00;
         end
      endcase
      return r;
   endfunction : read_byte

   // processor byte write into the registers and the stacking buffer
   function automatic sacr_pkg::sacr_state_t reg_write(input sacr_pkg::sacr_state_t s,
                                                       input logic [11:0] qa,
                                                       input logic [1:0] lane,
                                                       input logic [7:0] b);
      sacr_pkg::sacr_state_t r;
      r = s;
      unique case (qa)
         // control quadlet, response code lane included
         sacr_pkg::CTRL_ADDR: begin
            r.ctrl = put_byte(s.ctrl, lane, b);
         end
         // status quadlet
         sacr_pkg::STAT_ADDR: begin
            r.stat = put_byte(s.stat, lane, b);
         end
         // rom quadlet address and go bits
         sacr_pkg::ROMA_ADDR: begin
            r.roma = put_byte(s.roma, lane, b);
         end
         sacr_pkg::ROMD_ADDR: begin
            r.romd = put_byte(s.romd, lane, b);
         end
         // lowest address msb
         // lanes written out of order leave a mixed quadlet behind
         sacr_pkg::FIFO_ADDR, sacr_pkg::LAST_ADDR: begin
            r.stack = put_byte(s.stack, lane, b);
         end
         // unmapped writes are dropped
         default: begin
            r = s;
         end
      endcase
      return r;
   endfunction : reg_write

   // hardware status events; they land after any processor write
   function automatic logic [31:0] stat_events(input logic [31:0] q, input logic login_set,
                                               input logic state_wr,
                                               input sacr_pkg::sacr_agent_t state);
      logic [31:0] r;
      r = q;
      if (login_set) begin
         r[sacr_pkg::MGMT_BIT] = 1'b1;
      end
      if (state_wr) begin
         r[sacr_pkg::STATE_LSB +: 2] = state;
      end
      return r;
   endfunction : stat_events

   // serial loader finished: the part comes up initialised and valid
   function automatic logic [31:0] boot_init(input logic [31:0] q);
      logic [31:0] r;
      r = q;
      r[sacr_pkg::INIT_BIT] = 1'b1;
      r[sacr_pkg::CFGV_BIT] = 1'b1;
      return r;
   endfunction : boot_init

   // a finished rom operation drops both go bits
   function automatic logic [31:0] go_clear(input logic [31:0] q);
      logic [31:0] r;
      r = q;
      r[sacr_pkg::RRD_BIT] = 1'b0;
      r[sacr_pkg::RWR_BIT] = 1'b0;
      return r;
   endfunction : go_clear

   // unsolicited send drops once the status FIFO has drained
   function automatic logic [31:0] unsol_clear(input logic [31:0] q, input logic sending,
                                               input logic drained);
      logic [31:0] r;
      r = q;
      if (sending && drained) begin
         r[sacr_pkg::UNSOL_BIT] = 1'b0;
      end
      return r;
   endfunction : unsol_clear

   // link levels follow the next register contents
   function automatic sacr_pkg::sacr_link_t link_levels(input sacr_pkg::sacr_link_t l,
                                                        input sacr_pkg::sacr_state_t s);
      sacr_pkg::sacr_link_t r;
      r = l;
      r.csr_autoresp_disable = s.ctrl[sacr_pkg::CSRDIS_BIT];
      r.backplane_mode = s.ctrl[sacr_pkg::BKPL_BIT];
      r.ack_tardy = !s.ctrl[sacr_pkg::INIT_BIT];
      r.rom_autoresp = s.ctrl[sacr_pkg::CFGV_BIT];
      r.rom_quadlet_addr = s.roma[sacr_pkg::RADDR_LSB +: RADDR_W];
      r.rom_rd_req = s.roma[sacr_pkg::RRD_BIT];
      r.rom_wr_req = s.roma[sacr_pkg::RWR_BIT];
      r.unsol_xmit = s.stat[sacr_pkg::UNSOL_BIT];
      return r;
   endfunction : link_levels

   // two-stage synchroniser for the serial rom loader pin; the first flop
   // may go metastable, so nothing but the second flop reads it
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         boot_sync_q <= 2'h0;
      end else begin
         boot_sync_q <= {boot_sync_q[0], rom_load_done_i};
      end
   end

   // next-state logic
   always_comb begin
      logic [1:0] ln;
      logic [11:0] qa;
      logic at_last;
      ln = bus_i.addr[1:0];
      qa = quad_base(bus_i.addr);
      at_last = (qa == sacr_pkg::LAST_ADDR);
      s_d = s_q;

      // one-cycle strobes drop unless raised again below
      s_d.link.resp_send = 1'b0;
      s_d.link.fifo_push = 1'b0;
      s_d.link.fifo_last = 1'b0;

      // a read byte stands for one cycle after its strobe
      s_d.rdata = 8'h00;
      if (bus_i.rd) begin
         s_d.rdata = read_byte(s_q, qa, ln);
      end

      // byte writes; the hardware events further down win over them
      if (bus_i.wr) begin
         s_d = reg_write(s_d, qa, ln, bus_i.wdata);
         if (qa == sacr_pkg::CTRL_ADDR && ln == RCODE_LANE) begin
            s_d.link.resp_send = 1'b1;
            s_d.link.resp_code = bus_i.wdata;
         end
         if ((qa == sacr_pkg::FIFO_ADDR || at_last) && ln == sacr_pkg::LANE_LAST) begin
            s_d.link.fifo_push = 1'b1;
            s_d.link.fifo_last = at_last;
            s_d.link.fifo_data = s_d.stack;
         end
      end

      // serial load completes init; taken once per reset so that a
      // later processor clear of either bit sticks
      if (boot_sync_q[1] && !s_q.boot_seen) begin
         s_d.boot_seen = 1'b1;
         s_d.ctrl = boot_init(s_d.ctrl);
      end

      // login and agent state events
      s_d.stat = stat_events(s_d.stat, mgmt_login_set_i, agent_state_wr_i, agent_state_i);

      if (rom_op_done_i) begin
         if (s_q.roma[sacr_pkg::RRD_BIT]) begin
            s_d.romd = rom_rdata_i;
         end
         s_d.roma = go_clear(s_d.roma);
      end

      // drained FIFO ends an unsolicited send
      s_d.stat = unsol_clear(s_d.stat, s_q.link.unsol_xmit, status_fifo_empty_i);

      s_d.ctrl = ctrl_clean(s_d.ctrl);
      s_d.stat = stat_clean(s_d.stat);
      s_d.roma = roma_clean(s_d.roma);

      // level outputs follow the next register contents
      s_d.link = link_levels(s_d.link, s_d);
   end

   // state register
   always_ff @(posedge ref_clk_i) begin
      // clear at reset; ack_tardy is the inverse of a cleared init_done
      if (reset_i) begin
         s_q <= '0;
         s_q.link.ack_tardy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign rdata_o = s_q.rdata;
   assign link_o = s_q.link;

endmodule : sacr_regs

// ### design/sacr_pkg.sv
package sacr_pkg;

   // register byte addresses on the 8-bit host bus
   localparam logic [11:0] CTRL_ADDR = 12'h060;
   localparam logic [11:0] STAT_ADDR = 12'h064;
   localparam logic [11:0] ROMD_ADDR = 12'h06C;
   localparam logic [11:0] FIFO_ADDR = 12'h070;
   localparam logic [11:0] LAST_ADDR = 12'h074;
   localparam logic [11:0] ROMA_ADDR = 12'h60C;

   // control register field positions (bit 0 is the lsb of the quadlet)
   localparam int RCODE_LSB = 8;
   localparam int CSRDIS_BIT = 3;
   localparam int BKPL_BIT = 2;
   localparam int INIT_BIT = 1;
   localparam int CFGV_BIT = 0;

   // status register field positions
   localparam int MGMT_BIT = 31;
   localparam int STATE_LSB = 29;
   localparam int UNSOL_BIT = 28;

   // rom address/command field positions
   localparam int RADDR_LSB = 2;
   localparam int RRD_BIT = 1;
   localparam int RWR_BIT = 0;

   localparam logic [31:0] QUAD_RESET = 32'h0000_0000;
   localparam logic [1:0] LANE_FIRST = 2'h0;
   localparam logic [1:0] LANE_LAST = 2'h3;

   typedef enum logic [1:0] {
      AGT_RESET,
      AGT_ACTIVE,
      AGT_SUSPENDED,
      AGT_DEAD
   } sacr_agent_t;

   // host bus byte access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } sacr_bus_t;

   // link-side command outputs
   typedef struct packed {
      logic resp_send;
      logic [7:0] resp_code;
      logic csr_autoresp_disable;
      logic backplane_mode;
      logic ack_tardy;
      logic rom_autoresp;
      logic rom_rd_req;
      logic rom_wr_req;
      logic [5:0] rom_quadlet_addr;
      logic fifo_push;
      logic fifo_last;
      logic [31:0] fifo_data;
      logic unsol_xmit;
   } sacr_link_t;

   // block state apart from the synchroniser pair
   typedef struct packed {
      logic [7:0] rdata;
      logic [31:0] ctrl;
      logic [31:0] stat;
      logic [31:0] roma;
      logic [31:0] romd;
      logic [31:0] stack;
      logic [1:0] lane;
      logic boot_seen;
      sacr_link_t link;
   } sacr_state_t;

endpackage : sacr_pkg

// ### verification/sacr_regs_properties.sv
`timescale 1ns/1ns
module sacr_regs_properties (
   // clock and host bus
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire sacr_pkg::sacr_bus_t bus_i,
   input wire logic [7:0] rdata_o,
   // agent and link side
   input wire logic rom_load_done_i,
   input wire logic mgmt_login_set_i,
   input wire logic agent_state_wr_i,
   input wire sacr_pkg::sacr_agent_t agent_state_i,
   input wire logic rom_op_done_i,
   input wire logic [31:0] rom_rdata_i,
   input wire logic status_fifo_empty_i,
   input wire sacr_pkg::sacr_link_t link_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // write to the control low byte
   wire logic wc = bus_i.wr && bus_i.addr == 12'h063;
   wire logic [7:0] d = bus_i.wdata;
   AST_RESP: assert property (bus_i.wr && bus_i.addr == 12'h062
      |=> link_o.resp_send && link_o.resp_code == $past(d)) else $error("resp");
   AST_CSR: assert property (wc |=> link_o.csr_autoresp_disable == $past(d[3]))
      else $error("csr");
   AST_BKPL: assert property (wc |=> link_o.backplane_mode == $past(d[2]))
      else $error("bkpl");
   AST_TARDY: assert property (wc |=> link_o.ack_tardy != $past(d[1]))
      else $error("tardy");
   AST_CFGV: assert property (wc |=> link_o.rom_autoresp == $past(d[0]))
      else $error("cfgv");
   AST_BOOT: assert property ($rose(rom_load_done_i)
      |-> ##[1:6] !link_o.ack_tardy && link_o.rom_autoresp) else $error("boot");
   AST_UNSOL: assert property (link_o.unsol_xmit && status_fifo_empty_i
      |-> ##[1:2] !link_o.unsol_xmit) else $error("unsol");
   AST_DONE: assert property (rom_op_done_i
      |=> !link_o.rom_rd_req && !link_o.rom_wr_req) else $error("done");
   AST_PUSH: assert property (link_o.fifo_push |-> $past(bus_i.wr) &&
      $past(bus_i.addr) == (link_o.fifo_last ? 12'h077 : 12'h073)) else $error("push");
   AST_RDZ: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("rdz");
   // main scenarios seen
   COV_RESP: cover property (link_o.resp_send);
   COV_LAST: cover property (link_o.fifo_push && link_o.fifo_last);
   COV_UNSOL: cover property (link_o.unsol_xmit ##1 !link_o.unsol_xmit);
endmodule : sacr_regs_properties

bind sacr_regs sacr_regs_properties props (.ref_clk_i, .reset_i, .bus_i, .rdata_o,
   .rom_load_done_i, .mgmt_login_set_i, .agent_state_wr_i, .agent_state_i, .rom_op_done_i,
   .rom_rdata_i, .status_fifo_empty_i, .link_o);

// ### verification/sacr_cpu_model.sv
`timescale 1ns/1ns
module sacr_cpu_model (
   // clock and read data
   input wire logic ref_clk_i,
   input wire logic [7:0] rdata_i,
   // host bus
   output sacr_pkg::sacr_bus_t bus_o
);
   initial bus_o = '0;
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk_i) bus_o <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk_i) bus_o <= '{1'b0, 1'b0, ~a, ~d};
      #1;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge ref_clk_i) bus_o <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk_i) bus_o <= '{1'b0, 1'b0, ~a, 8'hFF};
      #1 d = rdata_i;
   endtask : rd
   task automatic wq(input logic [11:0] a, input logic [31:0] q);
      for (int i = 0; i < 4; i++) wr(a + 12'(i), q[31-8*i -: 8]);
   endtask : wq
endmodule : sacr_cpu_model

// ### verification/tb_sacr_regs.sv
`timescale 1ns/1ns
module tb_sacr_regs;
   logic ref_clk_i, reset_i, rom_load_done_i, mgmt_login_set_i, agent_state_wr_i;
   logic rom_op_done_i, status_fifo_empty_i;
   logic [7:0] rdata_o, b;
   logic [31:0] rom_rdata_i;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   sacr_pkg::sacr_agent_t agent_state_i;
   sacr_pkg::sacr_bus_t bus_i;
   sacr_pkg::sacr_link_t link_o;
   wire logic [3:0] cf = {link_o.csr_autoresp_disable, link_o.backplane_mode,
      link_o.ack_tardy, link_o.rom_autoresp};
   // processor model and block
   sacr_cpu_model cpu (.ref_clk_i, .rdata_i(rdata_o), .bus_o(bus_i));
   sacr_regs dut (.ref_clk_i, .reset_i, .bus_i, .rdata_o, .rom_load_done_i, .mgmt_login_set_i,
      .agent_state_wr_i, .agent_state_i, .rom_op_done_i, .rom_rdata_i, .status_fifo_empty_i,
      .link_o);
   // 50 MHz clock
   initial begin
      ref_clk_i = 0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   // hang guard
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic done_pulse();
      @(posedge ref_clk_i) rom_op_done_i <= 1;
      @(posedge ref_clk_i) rom_op_done_i <= 0;
      #1;
   endtask : done_pulse
   task automatic t_ctrl();
      chk(cf, 4'h2);
      cpu.rd(12'h064, b);
      chk(b, 0);
      cpu.wr(12'h063, 8'h0E);
      chk(cf, 4'hC);
      cpu.wr(12'h063, 8'h03);
      chk(cf, 4'h1);
      cpu.wr(12'h062, 8'hA5);
      chk({link_o.resp_send, link_o.resp_code}, 9'h1A5);
      #20 chk(link_o.resp_send, 0);
      cpu.wr(12'h063, 8'h00);
      chk(cf, 4'h2);
      $display("ctrl done");
   endtask : t_ctrl
   task automatic t_stat();
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk_i) {agent_state_wr_i, mgmt_login_set_i} <= 2'b11;
         agent_state_i <= sacr_pkg::sacr_agent_t'(i);
         @(posedge ref_clk_i) {agent_state_wr_i, mgmt_login_set_i} <= 2'b00;
         cpu.rd(12'h064, b);
         chk(b[7:5], {1'b1, 2'(i)});
      end
      cpu.wr(12'h064, 8'h10);
      repeat (3) @(posedge ref_clk_i);
      #1 chk(link_o.unsol_xmit, 1);
      @(posedge ref_clk_i) status_fifo_empty_i <= 1;
      @(posedge ref_clk_i) status_fifo_empty_i <= 0;
      @(posedge ref_clk_i) #1 chk(link_o.unsol_xmit, 0);
      $display("stat done");
   endtask : t_stat
   task automatic t_rom();
      @(posedge ref_clk_i) rom_rdata_i <= 32'hC3A5_1E07;
      cpu.wr(12'h60F, 8'hAA);
      chk({link_o.rom_rd_req, link_o.rom_wr_req, link_o.rom_quadlet_addr}, 8'hAA);
      done_pulse();
      chk(link_o.rom_rd_req, 0);
      for (int i = 0; i < 4; i++) begin
         cpu.rd(12'h06C + 12'(i), b);
         chk(b, 32'hC3A5_1E07 >> (24 - 8 * i) & 32'hFF);
      end
      cpu.rd(12'h60F, b);
      chk(b, 8'hA8);
      cpu.wq(12'h06C, 32'h5A0F_3C96);
      cpu.wr(12'h60F, 8'h55);
      chk({link_o.rom_rd_req, link_o.rom_wr_req, link_o.rom_quadlet_addr}, 8'h55);
      done_pulse();
      chk(link_o.rom_wr_req, 0);
      cpu.rd(12'h06C, b);
      chk(b, 8'h5A);
      $display("rom done");
   endtask : t_rom
   task automatic t_fifo();
      cpu.wq(12'h070, 32'h1234_ABCD);
      chk({link_o.fifo_push, link_o.fifo_last}, 2'b10);
      chk(link_o.fifo_data, 32'h1234_ABCD);
      cpu.wq(12'h074, 32'h8765_0F0E);
      chk({link_o.fifo_push, link_o.fifo_last}, 2'b11);
      chk(link_o.fifo_data, 32'h8765_0F0E);
      @(posedge ref_clk_i) rom_load_done_i <= 1;
      repeat (6) @(posedge ref_clk_i);
      #1 chk(cf, 4'h1);
      $display("fifo and boot done");
   endtask : t_fifo
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   // reset, scenarios, verdict
   initial begin
      {reset_i, rom_load_done_i, mgmt_login_set_i, agent_state_wr_i} = 4'h8;
      {rom_op_done_i, status_fifo_empty_i, rom_rdata_i} = '0;
      agent_state_i = sacr_pkg::AGT_RESET;
      repeat (16) @(posedge ref_clk_i);
      reset_i <= 0;
      #1 t_ctrl();
      t_stat();
      t_rom();
      t_fifo();
      print_verdict();
   end
endmodule : tb_sacr_regs
